// ---- bench/ddr_burst_sram_monitor.sv ----
module ddr_burst_sram_monitor
    import ddr_sram_pkg::*;
(
    input wire logic    ref_clk_i,
    input wire logic    rst_b_i,
    input wire logic    link_clk_i,
    input wire logic    pll_disable_n_i,
    input wire logic    load_n_i,
    input wire logic    read_not_write_i,
    input wire logic    dq_oe_o,
    input wire logic    echo_out_pos_o,
    input wire logic    echo_out_neg_o,
    input wire logic    wr_note_valid_o,
    input wire wr_rec_s wr_note_o,
    input wire logic    wr_note_ready_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********************
    // Accepted read tracking and checks
    // ********************
    logic prev_q;
    logic rd_q;

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_q <= 1'b0;
            rd_q   <= 1'b0;
        end else begin
            prev_q <= !load_n_i && !prev_q;
            rd_q   <= !load_n_i && !prev_q && read_not_write_i;
        end
    end

    sequence rd_lone;
        rd_q ##2 !rd_q;
    endsequence

    sequence rd_dup;
        rd_q && !load_n_i && read_not_write_i ##1 load_n_i ##1 load_n_i;
    endsequence

    chk_echo_pair: assert property (
        @(posedge link_clk_i) disable iff (!rst_b_i)
        echo_out_pos_o != echo_out_neg_o) else $error("echo pair equal");
    chk_echo_runs: assert property (
        @(negedge link_clk_i) disable iff (!rst_b_i)
        $past(echo_out_pos_o) |-> echo_out_pos_o) else $error("echo stopped");
    chk_lat_on: assert property (
        @(negedge link_clk_i) disable iff (!rst_b_i)
        rd_q && pll_disable_n_i && !$past(rd_q, 2) |=> !dq_oe_o ##1 dq_oe_o
    ) else $error("latency on");
    chk_lat_off: assert property (
        @(negedge link_clk_i) disable iff (!rst_b_i)
        rd_q && !pll_disable_n_i |=> dq_oe_o [*2]) else $error("latency off");
    chk_rd_burst: assert property (
        @(posedge link_clk_i) disable iff (!rst_b_i)
        rd_q |=> dq_oe_o [*2]) else $error("short burst");
    chk_oe_release: assert property (
        @(posedge link_clk_i) disable iff (!rst_b_i)
        rd_lone |=> !dq_oe_o) else $error("oe stuck");
    chk_second_rd: assert property (
        @(posedge link_clk_i) disable iff (!rst_b_i)
        rd_dup |=> !dq_oe_o) else $error("dup read");
    chk_note_hold: assert property (
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        wr_note_valid_o && !wr_note_ready_i |=>
        wr_note_valid_o && $stable(wr_note_o)) else $error("note dropped");
endmodule

bind ddr_burst_sram ddr_burst_sram_monitor mon (.*);

// ---- bench/ddr_burst_sram_test.sv ----
module ddr_burst_sram_test
    import ddr_sram_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ********************
    // Clocks, design, partner and scenarios
    // ********************
    localparam int NOTE_ROOM = 4;
    logic              ref_clk_i       = 1'b0;
    logic              link_clk_i      = 1'b0;
    logic              rst_b_i         = 1'b0;
    logic              strap           = 1'b0;
    logic              pll_disable_n_i = 1'b1;
    logic              wr_note_ready_i = 1'b1;
    logic              out_timing_pos_i;
    logic              out_timing_neg_i;
    logic              load_n_i;
    logic              read_not_write_i;
    logic [LANES-1:0]  byte_lane_sel_n_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] dq_i;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe_o;
    logic              echo_out_pos_o;
    logic              echo_out_neg_o;
    logic              wr_note_valid_o;
    wr_rec_s           wr_note_o;
    logic              single_clk_mode_o;
    logic              pll_off_o;
    int                num_errors      = 0;
    int                total_checks    = 0;

    always #2 ref_clk_i = ~ref_clk_i;
    initial begin
        #0.7;
        forever #32 link_clk_i = ~link_clk_i;
    end
    assign out_timing_pos_i = strap | link_clk_i;
    assign out_timing_neg_i = strap | ~link_clk_i;

    ddr_burst_sram DUT (.*);
    sram_ctrl_model ctl (
        .link_clk_i       (link_clk_i),
        .pll_disable_n_i  (pll_disable_n_i),
        .rd_data_i        (dq_o),
        .rd_oe_i          (dq_oe_o),
        .load_n_o         (load_n_i),
        .read_not_write_o (read_not_write_i),
        .lane_sel_n_o     (byte_lane_sel_n_i),
        .addr_o           (addr_i),
        .wr_data_o        (dq_i)
    );

    task automatic chk(input logic [DATA_W-1:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic t_mem(input logic s, input logic p);
        logic [DATA_W-1:0] w[4];
        logic [DATA_W-1:0] m[4];
        logic [DATA_W-1:0] q[4];
        logic [LANES-1:0]  be[4];
        int                b;
        @(negedge ref_clk_i);
        rst_b_i         = 1'b0;
        strap           = s;
        pll_disable_n_i = p;
        repeat (4) @(negedge link_clk_i);
        @(negedge ref_clk_i);
        rst_b_i = 1'b1;
        repeat (6) @(negedge link_clk_i);
        chk(DATA_W'(single_clk_mode_o), DATA_W'(s));
        chk(DATA_W'(pll_off_o), DATA_W'(!p));
        for (int i = 0; i < BEATS; i++) begin
            w[i]  = {4{9'h0A5 + 9'(i)}};
            m[i]  = ~w[i];
            be[i] = 4'h0;
        end
        ctl.wr(21'h0000A6, w, be);
        for (int i = 0; i < BEATS; i++) begin
            be[i] = 4'h1 << i;
        end
        ctl.wr(21'h0000A6, m, be);
        for (int d = 0; d < 2; d++) begin
            ctl.rd(21'h0000A4, d[0], q);
            for (int i = 0; i < BEATS; i++) begin
                b = (i + 2) % 4;
                chk(q[i], (m[b] & ~(36'h1FF << 9 * b)) |
                    (w[b] & (36'h1FF << 9 * b)));
            end
        end
    endtask

    task automatic t_notes();
        logic [DATA_W-1:0] w[4];
        logic [LANES-1:0]  be[4];
        logic [ADDR_W-1:0] got[$];
        w  = '{default: 36'h000000000};
        be = '{default: 4'h0};
        @(negedge ref_clk_i);
        wr_note_ready_i = 1'b0;
        for (int k = 0; k < 5; k++) begin
            ctl.wr(ADDR_W'(k * 4), w, be);
        end
        repeat (20) @(negedge ref_clk_i);
        wr_note_ready_i = 1'b1;
        repeat (400) begin
            if (wr_note_valid_o === 1'b1) begin
                got.push_back(wr_note_o.addr);
            end
            @(negedge ref_clk_i);
        end
        chk(DATA_W'(got.size()), DATA_W'(NOTE_ROOM));
        foreach (got[k]) begin
            chk(DATA_W'(got[k]), DATA_W'(k * 4));
        end
    endtask

    initial begin
        t_mem(1'b0, 1'b1);
        t_mem(1'b0, 1'b0);
        t_mem(1'b1, 1'b1);
        t_notes();
        end_sim();
    end
endmodule

// ---- bench/sram_ctrl_model.sv ----
module sram_ctrl_model
    import ddr_sram_pkg::*;
(
    input  wire logic              link_clk_i,
    input  wire logic              pll_disable_n_i,
    input  wire logic [DATA_W-1:0] rd_data_i,
    input  wire logic              rd_oe_i,
    output logic                   load_n_o,
    output logic                   read_not_write_o,
    output logic [LANES-1:0]       lane_sel_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      wr_data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ********************
    // Controller side of the burst bus
    // ********************
    initial begin
        load_n_o         = 1'b1;
        read_not_write_o = 1'b0;
        lane_sel_n_o     = 4'hF;
        addr_o           = 21'h000000;
        wr_data_o        = 36'h000000000;
    end

    task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a,
                       input logic dup);
        @(negedge link_clk_i);
        load_n_o         <= 1'b0;
        read_not_write_o <= rd;
        addr_o           <= a;
        @(negedge link_clk_i);
        load_n_o         <= !dup;
        addr_o           <= ~a;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] w[4],
                      input logic [LANES-1:0] be[4]);
        cmd(1'b0, a, 1'b0);
        for (int i = 0; i < BEATS; i++) begin
            wr_data_o    <= w[i];
            lane_sel_n_o <= be[i];
            @(link_clk_i);
        end
        wr_data_o    <= ~w[3];
        lane_sel_n_o <= ~be[3];
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic dup,
                      output logic [DATA_W-1:0] q[4]);
        cmd(1'b1, a, dup);
        @(posedge link_clk_i);
        load_n_o <= 1'b1;
        if (pll_disable_n_i) begin
            @(negedge link_clk_i);
        end
        for (int i = 0; i < BEATS; i++) begin
            #8;
            q[i] = (rd_oe_i === 1'b1) ? rd_data_i : {DATA_W{1'bx}};
            @(link_clk_i);
        end
    endtask
endmodule

// ---- pkg/ddr_sram_pkg.sv ----
package ddr_sram_pkg;

    // ********************
    // Widths and depths
    // ********************
    localparam int DATA_W   = 36;
    localparam int LANE_W   = 9;
    localparam int LANES    = 4;
    localparam int BEATS    = 4;
    localparam int ADDR_W   = 21;
    localparam int MEM_AW   = 8;
    localparam int MEM_D    = 256;
    localparam int SCHED_N  = 8;
    localparam int BURST_W  = 2;

    // ********************
    // Timing
    // ********************
    localparam int REF_CLK_MHZ      = 250;
    localparam int PLL_OFF_FMAX_MHZ = 167;
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // ********************
    // Read schedule offsets in half cycles
    // ********************
    localparam int SLOT_HI    = 0;
    localparam int SLOT_LO    = 1;
    localparam int SLOT_STEP  = 2;
    localparam logic [2:0] LAT_PLL_ON  = 3'h1;
    localparam logic [2:0] LAT_PLL_OFF = 3'h0;

    // ********************
    // Write burst tracking
    // ********************
    typedef enum logic [2:0] {
        WR_IDLE   = 3'b001,
        WR_FIRST  = 3'b010,
        WR_SECOND = 3'b100
    } wr_state_e;

    localparam logic [1:0] BEAT_0 = 2'h0;
    localparam logic [1:0] BEAT_1 = 2'h1;
    localparam logic [1:0] BEAT_2 = 2'h2;
    localparam logic [1:0] BEAT_3 = 2'h3;

    // ********************
    // Carriers
    // ********************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
    } wr_rec_s;

    localparam int REC_W = ADDR_W;

    typedef struct packed {
        logic              v;
        logic [MEM_AW-1:0] idx;
    } slot_s;

    typedef struct packed {
        logic              v;
        logic [MEM_AW-1:0] idx;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  be_n;
    } beat_s;

endpackage

// ---- src/ddr_burst_sram.sv ----
// Contract
// - Capture write words on rising and falling link edges
// - Drive two free-running echo clocks always; both are held while the link reset is active
// - Single-clock mode echoes from input clock
// - Low PLL disable selects one-cycle mode
// - PLL on: first word 1.5 cycles
// - PLL off: first word 1 cycle
// - Commands sampled only on rising edge
// - Output timing on both link clock edges
// - Write words taken on both edges
// - Read data leaves through output registers
// - Direction and load registered on rising edge
// - Load low starts four-word burst; a write is dropped while the note FIFO is full
// - Byte selects gate lanes per word
// - Strap at start picks single-clock mode
// - Read right after command is ignored
module ddr_burst_sram
    import ddr_sram_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              link_clk_i,
    input  wire logic              out_timing_pos_i,
    input  wire logic              out_timing_neg_i,
    input  wire logic              pll_disable_n_i,
    input  wire logic              load_n_i,
    input  wire logic              read_not_write_i,
    input  wire logic [LANES-1:0]  byte_lane_sel_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_o,
    output logic                   echo_out_pos_o,
    output logic                   echo_out_neg_o,
    output logic                   wr_note_valid_o,
    output wr_rec_s                wr_note_o,
    input  wire logic              wr_note_ready_i,
    output logic                   single_clk_mode_o,
    output logic                   pll_off_o
);

    // ****************************************************************
    // Resets
    // ****************************************************************
    logic ref_rst_m_q;
    logic ref_rst_n_q;
    logic lnk_rst_m_q;
    logic lnk_rst_n_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_rst_m_q <= 1'b0;
            ref_rst_n_q <= 1'b0;
        end else begin
            ref_rst_m_q <= 1'b1;
            ref_rst_n_q <= ref_rst_m_q;
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lnk_rst_m_q <= 1'b0;
            lnk_rst_n_q <= 1'b0;
        end else begin
            lnk_rst_m_q <= 1'b1;
            lnk_rst_n_q <= lnk_rst_m_q;
        end
    end

    // ****************************************************************
    // Static pins and strap
    // ****************************************************************
    logic       pll_m_q;
    logic       pll_on_q;
    logic       strap_m_q;
    logic       strap_s_q;
    logic [1:0] strap_cnt_q;
    logic       single_clk_q;

    always_ff @(posedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            pll_m_q   <= 1'b1;
            pll_on_q  <= 1'b1;
            strap_m_q <= 1'b0;
            strap_s_q <= 1'b0;
        end else begin
            pll_m_q   <= pll_disable_n_i;
            pll_on_q  <= pll_m_q;
            strap_m_q <= out_timing_pos_i && out_timing_neg_i;
            strap_s_q <= strap_m_q;
        end
    end

    always_ff @(posedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            strap_cnt_q  <= 2'h0;
            single_clk_q <= 1'b0;
        end else if (strap_cnt_q != STRAP_WAIT) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == STRAP_WAIT - 2'h1) begin
                single_clk_q <= strap_s_q;
            end
        end
    end

    // ****************************************************************
    // Command acceptance
    // ****************************************************************
    logic              cmd_prev_q;
    logic              note_ready;
    logic              cmd_ok;
    logic              rd_take;
    logic              wr_take;
    logic              wr_pend_q;
    logic [ADDR_W-1:0] wr_pend_addr_q;
    logic [ADDR_W-1:0] wr_cur_addr_q;
    wr_state_e         wr_state_q;

    assign cmd_ok  = !load_n_i && !cmd_prev_q;
    assign rd_take = cmd_ok && read_not_write_i;
    assign wr_take = cmd_ok && !read_not_write_i && note_ready;

    always_ff @(posedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            cmd_prev_q <= 1'b0;
        end else begin
            cmd_prev_q <= rd_take || wr_take;
        end
    end

    // ****************************************************************
    // Write burst tracking
    // ****************************************************************
    always_ff @(posedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            wr_pend_q      <= 1'b0;
            wr_pend_addr_q <= '0;
            wr_cur_addr_q  <= '0;
            wr_state_q     <= WR_IDLE;
        end else begin
            wr_pend_q <= wr_take;
            if (wr_take) begin
                wr_pend_addr_q <= addr_i;
            end
            case (wr_state_q)
                WR_FIRST: begin
                    wr_state_q <= WR_SECOND;
                end
                default: begin
                    if (wr_pend_q) begin
                        wr_cur_addr_q <= wr_pend_addr_q;
                        wr_state_q    <= WR_FIRST;
                    end else begin
                        wr_state_q <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    function automatic logic [MEM_AW-1:0] beat_idx(
        input logic [ADDR_W-1:0] base,
        input logic [1:0]        beat
    );
        logic [1:0] low;
        low      = base[BURST_W-1:0] + beat;
        beat_idx = {base[MEM_AW-1:BURST_W], low};
    endfunction

    // ****************************************************************
    // Write word capture on both edges
    // ****************************************************************
    beat_s pos_beat;
    beat_s neg_beat_q;

    always_comb begin
        pos_beat.v    = 1'b0;
        pos_beat.idx  = beat_idx(wr_pend_addr_q, BEAT_0);
        pos_beat.data = dq_i;
        pos_beat.be_n = byte_lane_sel_n_i;
        if (wr_pend_q && (wr_state_q != WR_FIRST)) begin
            pos_beat.v = 1'b1;
        end else if (wr_state_q == WR_FIRST) begin
            pos_beat.v   = 1'b1;
            pos_beat.idx = beat_idx(wr_cur_addr_q, BEAT_2);
        end
    end

    always_ff @(negedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            neg_beat_q <= '0;
        end else begin
            neg_beat_q.data <= dq_i;
            neg_beat_q.be_n <= byte_lane_sel_n_i;
            neg_beat_q.v    <= (wr_state_q != WR_IDLE);
            if (wr_state_q == WR_SECOND) begin
                neg_beat_q.idx <= beat_idx(wr_cur_addr_q, BEAT_3);
            end else begin
                neg_beat_q.idx <= beat_idx(wr_cur_addr_q, BEAT_1);
            end
        end
    end

    // ****************************************************************
    // Read schedule in half-cycle slots
    // ****************************************************************
    slot_s       sched_q [SCHED_N];
    logic [2:0]  lat_off;

    assign lat_off = pll_on_q ? LAT_PLL_ON : LAT_PLL_OFF;

    always_ff @(posedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            for (int i = 0; i < SCHED_N; i++) begin
                sched_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < SCHED_N; i++) begin
                if (i + SLOT_STEP < SCHED_N) begin
                    sched_q[i] <= sched_q[i + SLOT_STEP];
                end else begin
                    sched_q[i] <= '0;
                end
            end
            if (rd_take) begin
                for (int b = 0; b < BEATS; b++) begin
                    sched_q[b + int'(lat_off)].v   <= 1'b1;
                    sched_q[b + int'(lat_off)].idx <=
                        beat_idx(addr_i, 2'(b));
                end
            end
        end
    end

    // ****************************************************************
    // Storage lanes with write bypass
    // ****************************************************************
    logic [DATA_W-1:0] rd_hi;
    logic [DATA_W-1:0] rd_lo;

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_W-1:0] arr [MEM_D];
        logic              pos_wr;
        logic              neg_wr;

        assign pos_wr = pos_beat.v && !pos_beat.be_n[l];
        assign neg_wr = neg_beat_q.v && !neg_beat_q.be_n[l];

        always_ff @(posedge link_clk_i) begin
            if (neg_wr) begin
                arr[neg_beat_q.idx] <= neg_beat_q.data[l*LANE_W +: LANE_W];
            end
            if (pos_wr) begin
                arr[pos_beat.idx] <= pos_beat.data[l*LANE_W +: LANE_W];
            end
        end

        always_comb begin
            rd_hi[l*LANE_W +: LANE_W] = arr[sched_q[SLOT_HI].idx];
            rd_lo[l*LANE_W +: LANE_W] = arr[sched_q[SLOT_LO].idx];
            if (neg_wr && (neg_beat_q.idx == sched_q[SLOT_HI].idx)) begin
                rd_hi[l*LANE_W +: LANE_W] =
                    neg_beat_q.data[l*LANE_W +: LANE_W];
            end
            if (pos_wr && (pos_beat.idx == sched_q[SLOT_HI].idx)) begin
                rd_hi[l*LANE_W +: LANE_W] =
                    pos_beat.data[l*LANE_W +: LANE_W];
            end
            if (neg_wr && (neg_beat_q.idx == sched_q[SLOT_LO].idx)) begin
                rd_lo[l*LANE_W +: LANE_W] =
                    neg_beat_q.data[l*LANE_W +: LANE_W];
            end
            if (pos_wr && (pos_beat.idx == sched_q[SLOT_LO].idx)) begin
                rd_lo[l*LANE_W +: LANE_W] =
                    pos_beat.data[l*LANE_W +: LANE_W];
            end
        end
    end

    // ****************************************************************
    // Output registers on both clock phases
    // ****************************************************************
    logic [DATA_W-1:0] hi_q;
    logic              hi_oe_q;
    logic [DATA_W-1:0] lo_pend_q;
    logic              lo_pend_oe_q;
    logic [DATA_W-1:0] lo_q;
    logic              lo_oe_q;

    always_ff @(posedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            hi_q         <= '0;
            hi_oe_q      <= 1'b0;
            lo_pend_q    <= '0;
            lo_pend_oe_q <= 1'b0;
        end else begin
            hi_q         <= rd_hi;
            hi_oe_q      <= sched_q[SLOT_HI].v;
            lo_pend_q    <= rd_lo;
            lo_pend_oe_q <= sched_q[SLOT_LO].v;
        end
    end

    always_ff @(negedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            lo_q    <= '0;
            lo_oe_q <= 1'b0;
        end else begin
            lo_q    <= lo_pend_q;
            lo_oe_q <= lo_pend_oe_q;
        end
    end

    assign dq_o    = link_clk_i ? hi_q : lo_q;
    assign dq_oe_o = link_clk_i ? hi_oe_q : lo_oe_q;

    // ****************************************************************
    // Echo clocks
    // ****************************************************************
    logic echo_p_tgl_q;
    logic echo_n_tgl_q;

    always_ff @(posedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            echo_p_tgl_q <= 1'b0;
        end else begin
            echo_p_tgl_q <= ~echo_p_tgl_q;
        end
    end

    always_ff @(negedge link_clk_i or negedge lnk_rst_n_q) begin
        if (!lnk_rst_n_q) begin
            echo_n_tgl_q <= 1'b0;
        end else begin
            echo_n_tgl_q <= ~echo_n_tgl_q;
        end
    end

    assign echo_out_pos_o = echo_p_tgl_q ^ echo_n_tgl_q;
    assign echo_out_neg_o = ~(echo_p_tgl_q ^ echo_n_tgl_q);

    // ****************************************************************
    // Write notes towards the core clock
    // ****************************************************************
    wr_rec_s note_in;
    wr_rec_s note_buf;
    logic    buf_valid;
    logic    cdc_ready;

    assign note_in.addr = addr_i;

    note_fifo2 #(
        .W (REC_W)
    ) u_fifo (
        .clk_i       (link_clk_i),
        .rst_n_i     (lnk_rst_n_q),
        .in_valid_i  (wr_take),
        .in_ready_o  (note_ready),
        .in_data_i   (note_in),
        .out_valid_o (buf_valid),
        .out_ready_i (cdc_ready),
        .out_data_o  (note_buf)
    );

    note_cdc #(
        .W (REC_W)
    ) u_cdc (
        .src_clk_i   (link_clk_i),
        .src_rst_n_i (lnk_rst_n_q),
        .in_valid_i  (buf_valid),
        .in_ready_o  (cdc_ready),
        .in_data_i   (note_buf),
        .dst_clk_i   (ref_clk_i),
        .dst_rst_n_i (ref_rst_n_q),
        .out_valid_o (wr_note_valid_o),
        .out_ready_i (wr_note_ready_i),
        .out_data_o  (wr_note_o)
    );

    // ****************************************************************
    // Mode status towards the core clock
    // ****************************************************************
    logic single_m_q;
    logic pll_off_m_q;

    always_ff @(posedge ref_clk_i or negedge ref_rst_n_q) begin
        if (!ref_rst_n_q) begin
            single_m_q        <= 1'b0;
            single_clk_mode_o <= 1'b0;
            pll_off_m_q       <= 1'b0;
            pll_off_o         <= 1'b0;
        end else begin
            single_m_q        <= single_clk_q;
            single_clk_mode_o <= single_m_q;
            pll_off_m_q       <= ~pll_on_q;
            pll_off_o         <= pll_off_m_q;
        end
    end

endmodule

// ---- src/note_cdc.sv ----
module note_cdc
    import ddr_sram_pkg::*;
#(
    parameter int W = REC_W
) (
    input  wire logic         src_clk_i,
    input  wire logic         src_rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         dst_clk_i,
    input  wire logic         dst_rst_n_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    // ****************************************************************
    // Source side
    // ****************************************************************
    logic [W-1:0] hold_q;
    logic         req_q;
    logic         ack_m_q;
    logic         ack_s_q;
    logic         ack_q;
    logic         req_m_q;
    logic         req_s_q;

    assign in_ready_o = (req_q == ack_s_q);

    always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
        if (!src_rst_n_i) begin
            hold_q  <= '0;
            req_q   <= 1'b0;
            ack_m_q <= 1'b0;
            ack_s_q <= 1'b0;
        end else begin
            ack_m_q <= ack_q;
            ack_s_q <= ack_m_q;
            if (in_valid_i && in_ready_o) begin
                hold_q <= in_data_i;
                req_q  <= ~req_q;
            end
        end
    end

    // ****************************************************************
    // Destination side
    // ****************************************************************
    always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
        if (!dst_rst_n_i) begin
            req_m_q     <= 1'b0;
            req_s_q     <= 1'b0;
            ack_q       <= 1'b0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end else begin
            req_m_q <= req_q;
            req_s_q <= req_m_q;
            if (out_valid_o && out_ready_i) begin
                out_valid_o <= 1'b0;
            end else if (!out_valid_o && (req_s_q != ack_q)) begin
                out_data_o  <= hold_q;
                out_valid_o <= 1'b1;
                ack_q       <= req_s_q;
            end
        end
    end

endmodule

// ---- src/note_fifo2.sv ----
module note_fifo2
    import ddr_sram_pkg::*;
#(
    parameter int W = REC_W
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    // ****************************************************************
    // Two entry storage
    // ****************************************************************
    logic [W-1:0] mem_q [2];
    logic         wptr_q;
    logic         rptr_q;
    logic [1:0]   cnt_q;
    logic         push;
    logic         pop;

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rptr_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            cnt_q  <= 2'h0;
        end else begin
            if (push) begin
                wptr_q <= ~wptr_q;
            end
            if (pop) begin
                rptr_q <= ~rptr_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule
